/* rtl/hsl_map.vh */
// Address map, field positions and reset values of the hub strap block
`ifndef HSL_MAP_VH
`define HSL_MAP_VH

// ---------------------------------------------------------------
// Register bus
// ---------------------------------------------------------------
`define HSL_AW          8
`define HSL_DW          32
`define HSL_ZERO        32'h0000_0000

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define HSL_ADDR_STRAP  8'h00
`define HSL_ADDR_OCLIVE 8'h04
`define HSL_ADDR_STAT   8'h08
`define HSL_ADDR_MASK   8'h0c
`define HSL_ADDR_CTRL   8'h10

// ---------------------------------------------------------------
// Strap register fields
// ---------------------------------------------------------------
`define HSL_STRAP_SEL0  0
`define HSL_STRAP_SEL1  1
`define HSL_STRAP_SEL2  2
`define HSL_STRAP_CODE  3
`define HSL_STRAP_MASK  5
`define HSL_STRAP_DONE  8

// ---------------------------------------------------------------
// Status and mask fields: bits 6..0 over-current onset of ports 7..1
// ---------------------------------------------------------------
`define HSL_NPORT       7
`define HSL_NEVT        8
`define HSL_EVT_SPEED   7
`define HSL_EVT_RST     8'h00
`define HSL_MASK_RST    8'h00

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define HSL_CTRL_LEDEN  0
`define HSL_CTRL_RST    1'h1

// ---------------------------------------------------------------
// Fixed-port codes and decoded masks of ports 3..1
// ---------------------------------------------------------------
`define HSL_CODE_NONE   2'h0
`define HSL_CODE_P1     2'h1
`define HSL_CODE_P12    2'h2
`define HSL_CODE_P123   2'h3
`define HSL_FIX_NONE    3'h0
`define HSL_FIX_P1      3'h1
`define HSL_FIX_P12     3'h3
`define HSL_FIX_P123    3'h7

`endif

/* rtl/hsl_strap_capture.v */
// Strap capture at reset release with fixed-port decode
`timescale 1ns/1ps
`default_nettype none
`include "hsl_map.vh"

module hsl_strap_capture (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       fixed_strap_en,
  input  wire       sel2_present,
  input  wire       serial_data_in,
  input  wire       suspend_led_in,
  input  wire       serial_clock_in,
  input  wire       highspeed_led_in,
  input  wire       cfg_method_sel_b2_in,
  output reg  [2:0] cfg_method_sel_r,
  output reg  [1:0] fixed_port_code_r,
  output reg  [2:0] fixed_port_mask_r,
  output reg        captured_r
);

  reg [2:0] fixed_port_mask_nxt;
  reg [1:0] fixed_port_code_nxt;

  always @* begin
    fixed_port_code_nxt = `HSL_CODE_NONE;
    if (fixed_strap_en) begin
      fixed_port_code_nxt = {serial_data_in, suspend_led_in};
    end
    case (fixed_port_code_nxt)
      `HSL_CODE_NONE: fixed_port_mask_nxt = `HSL_FIX_NONE;
      `HSL_CODE_P1:   fixed_port_mask_nxt = `HSL_FIX_P1;
      `HSL_CODE_P12:  fixed_port_mask_nxt = `HSL_FIX_P12;
      `HSL_CODE_P123: fixed_port_mask_nxt = `HSL_FIX_P123;
      default:        fixed_port_mask_nxt = `HSL_FIX_NONE;
    endcase
  end

  // Pins are caught on the first edge after release, then frozen until reset
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_method_sel_r  <= 3'h0;
      fixed_port_code_r <= `HSL_CODE_NONE;
      fixed_port_mask_r <= `HSL_FIX_NONE;
      captured_r        <= 1'b0;
    end else if (!captured_r) begin
      cfg_method_sel_r[0] <= serial_clock_in;
      cfg_method_sel_r[1] <= highspeed_led_in;
      cfg_method_sel_r[2] <= sel2_present & cfg_method_sel_b2_in;
      fixed_port_code_r   <= fixed_port_code_nxt;
      fixed_port_mask_r   <= fixed_port_mask_nxt;
      captured_r          <= 1'b1;
    end
  end

endmodule
`default_nettype wire

/* rtl/hsl_oc_sense.v */
// Per-port over-current sense: registered level and onset pulse
`timescale 1ns/1ps
`default_nettype none
`include "hsl_map.vh"

module hsl_oc_sense (
  input  wire                  clock,
  input  wire                  rst_n,
  input  wire [`HSL_NPORT-1:0] sense_n,
  output reg  [`HSL_NPORT-1:0] level_r,
  output reg  [`HSL_NPORT-1:0] onset_r
);

  genvar i;
  generate
    for (i = 0; i < `HSL_NPORT; i = i + 1) begin : g_port
      // A low input is an over-current report for that port
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          level_r[i] <= 1'b0;
          onset_r[i] <= 1'b0;
        end else begin
          level_r[i] <= ~sense_n[i];
          onset_r[i] <= ~sense_n[i] & ~level_r[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* rtl/hsl_top.v */
// Hub strap latch, upstream speed indicator and over-current sense block
//
// Behaviour
// - When enabled, the serial-data and suspend pins are sampled at reset release as a code for ports 3..1.
// - Code 00 leaves all ports removable, 01 fixes port 1, 10 ports 1-2, 11 ports 1-3.
// - The serial-clock pin level is latched at reset release as configuration select bit zero.
// - The speed indicator pin level is latched at reset release as configuration select bit one.
// - After reset the indicator is active high if select bit one is 0 and active low if it is 1.
// - The indicator is asserted while upstream runs at high speed and negated at full speed.
// - Seven active-low sense inputs report over-current on ports 7..1 when low.
// - Select bit two is latched at reset release and reads 0 where the pin is absent.
`timescale 1ns/1ps
`default_nettype none
`include "hsl_map.vh"

module hsl_top (
  input  wire                  clock,
  input  wire                  rst_n,
  // Register port
  input  wire [`HSL_AW-1:0]    addr,
  input  wire [`HSL_DW-1:0]    wdata,
  input  wire                  wr,
  input  wire                  rd,
  output reg  [`HSL_DW-1:0]    rdata_r,
  output reg                   irq_r,
  // Package and configuration
  input  wire                  fixed_strap_en,
  input  wire                  sel2_present,
  input  wire                  cfg_method_sel_b2,
  // Shared strap pins, sampled only
  input  wire                  serial_data_in,
  input  wire                  serial_clock_in,
  input  wire                  suspend_led_in,
  // Upstream speed indicator pin
  input  wire                  upstream_highspeed_led_in,
  output reg                   upstream_highspeed_led_out_r,
  output reg                   upstream_highspeed_led_oe_r,
  input  wire                  upstream_is_highspeed,
  // Over-current sense
  input  wire [`HSL_NPORT-1:0] port_overcurrent_sense_n,
  output reg  [`HSL_NPORT-1:0] port_overcurrent_r,
  // Latched straps
  output reg  [2:0]            cfg_method_sel_r,
  output reg  [1:0]            fixed_port_code_r,
  output reg  [2:0]            fixed_port_mask_r,
  output reg                   strap_done_r
);

  // ---------------------------------------------------------------
  // Strap capture and over-current sense
  // ---------------------------------------------------------------
  wire [2:0]            sel_cap;
  wire [1:0]            code_cap;
  wire [2:0]            mask_cap;
  wire                  captured;
  wire [`HSL_NPORT-1:0] oc_level;
  wire [`HSL_NPORT-1:0] oc_onset;

  hsl_strap_capture u_strap (
    .clock             (clock),
    .rst_n             (rst_n),
    .fixed_strap_en    (fixed_strap_en),
    .sel2_present      (sel2_present),
    .serial_data_in    (serial_data_in),
    .suspend_led_in    (suspend_led_in),
    .serial_clock_in   (serial_clock_in),
    .highspeed_led_in  (upstream_highspeed_led_in),
    .cfg_method_sel_b2_in       (cfg_method_sel_b2),
    .cfg_method_sel_r  (sel_cap),
    .fixed_port_code_r (code_cap),
    .fixed_port_mask_r (mask_cap),
    .captured_r        (captured)
  );

  hsl_oc_sense u_oc (
    .clock   (clock),
    .rst_n   (rst_n),
    .sense_n (port_overcurrent_sense_n),
    .level_r (oc_level),
    .onset_r (oc_onset)
  );

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  reg  [`HSL_NEVT-1:0] stat_r;
  reg  [`HSL_NEVT-1:0] stat_nxt;
  reg  [`HSL_NEVT-1:0] mask_r;
  reg                  led_en_r;
  reg                  speed_r;
  reg  [`HSL_DW-1:0]   rdata_nxt;
  wire                 speed_evt;
  wire [`HSL_NEVT-1:0] events;
  wire [`HSL_NEVT-1:0] w1c;
  wire                 wr_stat;
  wire                 wr_mask;
  wire                 wr_ctrl;

  assign wr_stat = wr & (addr == `HSL_ADDR_STAT);
  assign wr_mask = wr & (addr == `HSL_ADDR_MASK);
  assign wr_ctrl = wr & (addr == `HSL_ADDR_CTRL);

  // Speed changes only count once the indicator pin has been released by the strap
  assign speed_evt = captured & (upstream_is_highspeed ^ speed_r);
  assign events    = {speed_evt, oc_onset};
  assign w1c       = wr_stat ? wdata[`HSL_NEVT-1:0] : `HSL_EVT_RST;

  // A new event in the clearing cycle survives the clear
  always @* begin
    stat_nxt = (stat_r & ~w1c) | events;
  end

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  always @* begin
    rdata_nxt = `HSL_ZERO;
    if (rd) begin
      case (addr)
        `HSL_ADDR_STRAP: begin
          rdata_nxt[`HSL_STRAP_SEL0]         = cfg_method_sel_r[0];
          rdata_nxt[`HSL_STRAP_SEL1]         = cfg_method_sel_r[1];
          rdata_nxt[`HSL_STRAP_SEL2]         = cfg_method_sel_r[2];
          rdata_nxt[`HSL_STRAP_CODE+1 -: 2]  = fixed_port_code_r;
          rdata_nxt[`HSL_STRAP_MASK+2 -: 3]  = fixed_port_mask_r;
          rdata_nxt[`HSL_STRAP_DONE]         = strap_done_r;
        end
        `HSL_ADDR_OCLIVE: rdata_nxt[`HSL_NPORT-1:0]     = port_overcurrent_r;
        `HSL_ADDR_STAT:   rdata_nxt[`HSL_NEVT-1:0]      = stat_r;
        `HSL_ADDR_MASK:   rdata_nxt[`HSL_NEVT-1:0]      = mask_r;
        `HSL_ADDR_CTRL:   rdata_nxt[`HSL_CTRL_LEDEN]    = led_en_r;
        default:          rdata_nxt                     = `HSL_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers, interrupt and outputs
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_r             <= `HSL_EVT_RST;
      mask_r             <= `HSL_MASK_RST;
      led_en_r           <= `HSL_CTRL_RST;
      speed_r            <= 1'b0;
      rdata_r            <= `HSL_ZERO;
      irq_r              <= 1'b0;
      port_overcurrent_r <= {`HSL_NPORT{1'b0}};
      cfg_method_sel_r   <= 3'h0;
      fixed_port_code_r  <= `HSL_CODE_NONE;
      fixed_port_mask_r  <= `HSL_FIX_NONE;
      strap_done_r       <= 1'b0;
    end else begin
      stat_r             <= stat_nxt;
      rdata_r            <= rdata_nxt;
      irq_r              <= |(stat_r & mask_r);
      port_overcurrent_r <= oc_level;
      cfg_method_sel_r   <= sel_cap;
      fixed_port_code_r  <= code_cap;
      fixed_port_mask_r  <= mask_cap;
      strap_done_r       <= captured;
      // Tracked from reset on, so a link already at high speed at release is no event
      speed_r            <= upstream_is_highspeed;
      if (wr_mask) begin
        mask_r <= wdata[`HSL_NEVT-1:0];
      end
      if (wr_ctrl) begin
        led_en_r <= wdata[`HSL_CTRL_LEDEN];
      end
    end
  end

  // ---------------------------------------------------------------
  // Upstream speed indicator
  // ---------------------------------------------------------------
  // The pin is left undriven until the strap is taken, so the board level
  // is what gets latched; the polarity then follows the latched bit.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      upstream_highspeed_led_oe_r  <= 1'b0;
      upstream_highspeed_led_out_r <= 1'b0;
    end else begin
      upstream_highspeed_led_oe_r  <= captured;
      upstream_highspeed_led_out_r <=
        (led_en_r & upstream_is_highspeed) ^ sel_cap[1];
    end
  end

endmodule
`default_nettype wire

/* tb/hsl_asserts.sv */
// Port-level checker of the hub strap block
`timescale 1ns/1ps
`default_nettype none
module hsl_asserts (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       fixed_strap_en,
  input wire logic       sel2_present,
  input wire logic       cfg_method_sel_b2,
  input wire logic       serial_data_in,
  input wire logic       serial_clock_in,
  input wire logic       suspend_led_in,
  input wire logic       upstream_highspeed_led_in,
  input wire logic       upstream_highspeed_led_out_r,
  input wire logic       upstream_highspeed_led_oe_r,
  input wire logic       upstream_is_highspeed,
  input wire logic [6:0] port_overcurrent_sense_n,
  input wire logic [6:0] port_overcurrent_r,
  input wire logic [2:0] cfg_method_sel_r,
  input wire logic [1:0] fixed_port_code_r,
  input wire logic [2:0] fixed_port_mask_r,
  input wire logic       strap_done_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // Strap capture, indicator and sense
  // ---------------------------------------------------------------
  // Pins are caught one edge before the latched copies show up, hence a depth of two
  sel_capture_a: assert property (
    $rose(strap_done_r) |-> cfg_method_sel_r ==
    {$past(cfg_method_sel_b2, 2) & $past(sel2_present, 2),
    $past(upstream_highspeed_led_in, 2), $past(serial_clock_in, 2)})
    else $error("select bits differ from pins at release");
  code_capture_a: assert property (
    $rose(strap_done_r) |-> fixed_port_code_r == ($past(fixed_strap_en, 2) ?
    {$past(serial_data_in, 2), $past(suspend_led_in, 2)} : 2'h0))
    else $error("fixed port code differs from pins at release");
  fix_decode_a: assert property (
    strap_done_r |-> fixed_port_mask_r == {&fixed_port_code_r, fixed_port_code_r[1],
    |fixed_port_code_r}) else $error("fixed port mask wrong for code");
  strap_hold_a: assert property (
    strap_done_r |=> $stable(cfg_method_sel_r) && $stable(fixed_port_code_r)
    && $stable(fixed_port_mask_r) && strap_done_r) else $error("latched strap moved");
  led_negate_a: assert property (
    $fell(upstream_is_highspeed) && strap_done_r |=>
    upstream_highspeed_led_out_r == cfg_method_sel_r[1]) else $error("indicator not negated");
  oe_before_a: assert property (
    !strap_done_r |-> !upstream_highspeed_led_oe_r) else $error("indicator driven early");
  oe_hold_a: assert property (
    strap_done_r |=> upstream_highspeed_led_oe_r) else $error("indicator drive dropped");
  // Sense passes a level stage and the output stage, two edges in all
  oc_level_a: assert property (
    $past(rst_n) && $past(rst_n, 2) |->
    port_overcurrent_r == ~$past(port_overcurrent_sense_n, 2))
    else $error("over-current level not the inverted sense");
endmodule
`default_nettype wire

/* tb/hsl_board.sv */
// Board model: strap resistors, indicator pin and current monitors
`timescale 1ns/1ps
`default_nettype none
module hsl_board (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [4:0] strap,
  input  wire logic [6:0] fault,
  input  wire logic       led_out,
  input  wire logic       led_oe,
  output logic            sel0_pin,
  output logic            led_pin,
  output logic            sel2_pin,
  output logic            hi_pin,
  output logic            lo_pin,
  output logic [6:0]      sense_n
);
  logic [3:0] age_r;
  logic       tog_r;
  logic       busy;
  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      age_r <= 4'h0;
      tog_r <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      if (!age_r[3]) age_r <= age_r + 4'h1;
    end
  end
  // Shared pins turn to bus traffic soon after release, so a late sample shows garbage
  assign busy     = |age_r[3:2];
  assign sel0_pin = busy ? tog_r : strap[0];
  assign hi_pin   = busy ? ~tog_r : strap[4];
  assign lo_pin   = busy ? tog_r : strap[3];
  assign sel2_pin = strap[2];
  assign led_pin  = led_oe ? led_out : strap[1];
  // Idle monitors leave the line to its pull-up
  assign sense_n  = ~fault;
endmodule
`default_nettype wire

/* tb/hsl_top_tb.sv */
// Self-checking bench of the hub strap block
`timescale 1ns/1ps
`default_nettype none
`include "hsl_map.vh"
module hsl_top_tb;
  logic        clock, rst_n, wr, rd, irq_r, fixed_strap_en, sel2_present, cfg_method_sel_b2;
  logic        serial_data_in, serial_clock_in, suspend_led_in, upstream_highspeed_led_in;
  logic        upstream_highspeed_led_out_r, upstream_highspeed_led_oe_r, strap_done_r;
  logic        upstream_is_highspeed, rd_d, s2;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata_r, seed, r, expw, exp_q[$];
  logic [6:0]  port_overcurrent_sense_n, port_overcurrent_r, fault, pm;
  logic [4:0]  strap;
  logic [2:0]  cfg_method_sel_r, fixed_port_mask_r;
  logic [1:0]  fixed_port_code_r, code;
  int          fail_count, checks_done;
  hsl_top uut (.clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata_r, .irq_r, .fixed_strap_en,
    .sel2_present, .cfg_method_sel_b2, .serial_data_in, .serial_clock_in, .suspend_led_in,
    .upstream_highspeed_led_in, .upstream_highspeed_led_out_r, .upstream_highspeed_led_oe_r,
    .upstream_is_highspeed, .port_overcurrent_sense_n, .port_overcurrent_r,
    .cfg_method_sel_r, .fixed_port_code_r, .fixed_port_mask_r, .strap_done_r);
  hsl_board brd (.clock, .rst_n, .strap, .fault, .led_out(upstream_highspeed_led_out_r),
    .led_oe(upstream_highspeed_led_oe_r), .sel0_pin(serial_clock_in),
    .led_pin(upstream_highspeed_led_in), .sel2_pin(cfg_method_sel_b2),
    .hi_pin(serial_data_in), .lo_pin(suspend_led_in), .sense_n(port_overcurrent_sense_n));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_t(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_t(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    rd <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_d) chk(rdata_r, exp_q.pop_front());
    rd_d <= rd;
  end
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // Scenarios: each pass is a fresh reset with new straps
  // ---------------------------------------------------------------
  initial begin
    {rst_n, wr, rd, fixed_strap_en, sel2_present, upstream_is_highspeed} = 6'h0;
    {addr, wdata, strap, fault} = 52'h0;
    seed = 32'h7;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      r = rnd();
      rst_n <= 1'b0;
      upstream_is_highspeed <= 1'b0;
      fault <= 7'h00;
      strap <= {i[1:0], r[2:0]};
      fixed_strap_en <= (i < 4) | r[4];
      sel2_present <= r[3];
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      repeat (8) @(posedge clock);
      code = fixed_strap_en ? strap[4:3] : 2'h0;
      s2 = strap[2] & sel2_present;
      expw = {23'h0, 1'b1, &code, code[1], |code, code, s2, strap[1:0]};
      chk({29'h0, cfg_method_sel_r}, {29'h0, s2, strap[1:0]});
      r = {23'h0, strap_done_r, fixed_port_mask_r, fixed_port_code_r, cfg_method_sel_r};
      chk(r, expw);
      rd_t(`HSL_ADDR_STRAP, expw);
      rd_t(`HSL_ADDR_OCLIVE, 32'h0);
      rd_t(`HSL_ADDR_STAT, 32'h0);
      rd_t(`HSL_ADDR_MASK, 32'h0);
      rd_t(`HSL_ADDR_CTRL, 32'h1);
      rd_t(8'h14, 32'h0);
      wr_t(`HSL_ADDR_STRAP, 32'hffff_ffff);
      rd_t(`HSL_ADDR_STRAP, expw);
      upstream_is_highspeed <= 1'b1;
      repeat (2) @(posedge clock);
      r = {30'h0, upstream_highspeed_led_oe_r, upstream_highspeed_led_out_r};
      chk(r, {30'h1, ~strap[1]});
      wr_t(`HSL_ADDR_CTRL, 32'h0);
      repeat (2) @(posedge clock);
      chk({31'h0, upstream_highspeed_led_out_r}, {31'h0, strap[1]});
      wr_t(`HSL_ADDR_CTRL, 32'h1);
      upstream_is_highspeed <= 1'b0;
      repeat (2) @(posedge clock);
      chk({31'h0, upstream_highspeed_led_out_r}, {31'h0, strap[1]});
      rd_t(`HSL_ADDR_STAT, 32'h80);
      wr_t(`HSL_ADDR_STAT, 32'hff);
      wr_t(`HSL_ADDR_MASK, 32'h7f);
      pm = 7'h1 << (rnd() % 7);
      fault <= pm;
      repeat (5) @(posedge clock);
      chk({24'h0, irq_r, port_overcurrent_r}, {24'h1, pm});
      rd_t(`HSL_ADDR_OCLIVE, {25'h0, pm});
      rd_t(`HSL_ADDR_STAT, {25'h0, pm});
      wr_t(`HSL_ADDR_MASK, 32'h0);
      repeat (2) @(posedge clock);
      chk({31'h0, irq_r}, 32'h0);
      wr_t(`HSL_ADDR_MASK, 32'h7f);
      wr_t(`HSL_ADDR_STAT, {25'h0, pm});
      repeat (2) @(posedge clock);
      chk({31'h0, irq_r}, 32'h0);
      rd_t(`HSL_ADDR_STAT, 32'h0);
    end
    repeat (2) @(posedge clock);
    wrap_up();
  end
endmodule
bind hsl_top hsl_asserts chk_i (.clock, .rst_n, .fixed_strap_en, .sel2_present,
  .cfg_method_sel_b2, .serial_data_in, .serial_clock_in, .suspend_led_in,
  .upstream_highspeed_led_in, .upstream_highspeed_led_out_r, .upstream_highspeed_led_oe_r,
  .upstream_is_highspeed, .port_overcurrent_sense_n, .port_overcurrent_r, .cfg_method_sel_r,
  .fixed_port_code_r, .fixed_port_mask_r, .strap_done_r);
`default_nettype wire
